/* File: bench/cache_diag_error_regs_test.sv */
// Purpose: Self-checking bench for the cache diagnostic and error registers.
// Assumes: Array model answers loads at once; all stimulus moves on the rising edge.
// Notes: Each scenario is a task that drives and judges on its own.
`include "cdr_params.svh"
`define CHECK(got, want) begin check_count++; if ((got) !== (want)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, want); end end
module cache_diag_error_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0, rst_n = 1'h0, move_to_control = 1'h0, move_from_control = 1'h0, maintenance_op = 1'h0;
  logic err_valid = 1'h0, error_trap_disable = 1'h0, fault_release = 1'h0, inconsistent_block_error = 1'h0;
  logic sysbus_address_fault = 1'h0, sysbus_command_fault = 1'h0, sysbus_response_fault = 1'h0;
  logic [1:0] err_data_way = 2'h0, err_tag_way = 2'h0, err_state_way = 2'h0, err_mod_way = 2'h0;
  logic [4:0] cp0_addr = 5'h00;
  logic [22:6] err_addr = 17'h0;
  logic [31:0] cp0_wdata = 32'h0, cp0_rdata, store_low, store_high, array_low, array_high, kept_low;
  logic [9:0] store_check, array_check, kept_check;
  logic cp0_rvalid, store_valid, cache_error_trap, ecc_corrected, tag_parity_bad;
  cdr_pkg::cdr_op_t op_kind = cdr_pkg::CDR_OP_LOAD_TAG;
  cdr_pkg::cdr_target_t op_target = cdr_pkg::CDR_TGT_ICACHE;
  cdr_pkg::cdr_err_t err_kind = cdr_pkg::CDR_ERR_PARITY;
  cdr_pkg::cdr_source_t err_source = cdr_pkg::CDR_SRC_ICACHE;
  cdr_pkg::cdr_line_state_t dcache_line_state;
  int bad_count = 0, check_count = 0, cycles = 0;

  cdr_regs #(.LARGE_BLOCK(1'h0)) DUT (.core_clk, .rst_n, .move_to_control, .move_from_control, .cp0_addr,
    .cp0_wdata, .cp0_rdata, .cp0_rvalid, .maintenance_op, .op_kind, .op_target, .array_low, .array_high,
    .array_check, .store_valid, .store_low, .store_high, .store_check, .err_valid, .err_kind, .err_source,
    .err_data_way, .err_tag_way, .err_state_way, .err_mod_way, .inconsistent_block_error, .sysbus_address_fault,
    .sysbus_command_fault, .sysbus_response_fault, .err_addr, .error_trap_disable, .fault_release,
    .cache_error_trap, .ecc_corrected, .dcache_line_state, .tag_parity_bad);
  cdr_array_model partner (.core_clk, .array_low, .array_high, .array_check, .store_valid, .store_low,
    .store_check, .kept_low, .kept_check);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // A hung handshake ends the run as a failure.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cp0_addr <= a;
    cp0_wdata <= d;
    move_to_control <= 1'h1;
    @(posedge core_clk);
    move_to_control <= 1'h0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] want);
    @(posedge core_clk);
    cp0_addr <= a;
    move_from_control <= 1'h1;
    @(posedge core_clk);
    move_from_control <= 1'h0;
    #1;
    `CHECK(cp0_rvalid, 1'h1)
    `CHECK(cp0_rdata, want)
  endtask : rd

  task automatic op(input cdr_pkg::cdr_op_t k, input cdr_pkg::cdr_target_t t);
    @(posedge core_clk);
    op_kind <= k;
    op_target <= t;
    maintenance_op <= 1'h1;
    @(posedge core_clk);
    maintenance_op <= 1'h0;
    @(posedge core_clk);
    #1;
  endtask : op

  task automatic err(input cdr_pkg::cdr_err_t k, input cdr_pkg::cdr_source_t s, input logic [22:6] a,
      input logic [11:0] f, input logic dis, input logic trap);
    @(posedge core_clk);
    {err_data_way, err_tag_way, err_state_way, err_mod_way, inconsistent_block_error, sysbus_address_fault,
      sysbus_command_fault, sysbus_response_fault} <= f;
    err_kind <= k;
    err_source <= s;
    err_addr <= a;
    error_trap_disable <= dis;
    err_valid <= 1'h1;
    fault_release <= 1'h0;
    @(posedge core_clk);
    err_valid <= 1'h0;
    #1;
    `CHECK(cache_error_trap, trap)
    `CHECK(ecc_corrected, k == cdr_pkg::CDR_ERR_SINGLE)
    @(posedge core_clk);
    fault_release <= 1'h0;
  endtask : err

  task automatic t_moves();
    wr(`CDR_REG_STAGING_LOW, 32'hdead_beef);
    rd(`CDR_REG_STAGING_LOW, 32'hdead_beef);
    wr(`CDR_REG_STAGING_HIGH, 32'h1234_5678);
    rd(`CDR_REG_STAGING_HIGH, 32'h1234_5678);
    wr(`CDR_REG_CHECK_BITS, 32'h0000_02a5);
    rd(`CDR_REG_CHECK_BITS, 32'h0000_02a5);
    wr(`CDR_REG_FAULT_CAPTURE, 32'hffff_ffff);
    rd(`CDR_REG_FAULT_CAPTURE, 32'h0);
  endtask : t_moves

  task automatic t_loads();
    op(cdr_pkg::CDR_OP_LOAD_DATA, cdr_pkg::CDR_TGT_ICACHE);
    rd(`CDR_REG_CHECK_BITS, 32'h001);
    rd(`CDR_REG_STAGING_HIGH, 32'h0000_000f);
    op(cdr_pkg::CDR_OP_LOAD_DATA, cdr_pkg::CDR_TGT_DCACHE);
    rd(`CDR_REG_CHECK_BITS, 32'h00f);
    rd(`CDR_REG_STAGING_HIGH, 32'h0);
    op(cdr_pkg::CDR_OP_LOAD_DATA, cdr_pkg::CDR_TGT_SCACHE);
    rd(`CDR_REG_CHECK_BITS, 32'h3ff);
    op(cdr_pkg::CDR_OP_LOAD_TAG, cdr_pkg::CDR_TGT_ICACHE);
    `CHECK(tag_parity_bad, 1'h1)
    rd(`CDR_REG_STAGING_LOW, 32'hffff_ffc3);
    rd(`CDR_REG_CHECK_BITS, 32'h3ff);
    op(cdr_pkg::CDR_OP_LOAD_TAG, cdr_pkg::CDR_TGT_DCACHE);
    rd(`CDR_REG_STAGING_HIGH, 32'he000_000f);
    `CHECK(dcache_line_state, cdr_pkg::CDR_LS_REFILL_DIRTY)
  endtask : t_loads

  task automatic t_stores();
    wr(`CDR_REG_CHECK_BITS, 32'h3ff);
    op(cdr_pkg::CDR_OP_STORE_DATA, cdr_pkg::CDR_TGT_DCACHE);
    `CHECK(kept_check, 10'h00f)
    op(cdr_pkg::CDR_OP_STORE_DATA, cdr_pkg::CDR_TGT_SCACHE);
    `CHECK(kept_check, 10'h3ff)
    wr(`CDR_REG_STAGING_LOW, 32'hffff_ffff);
    op(cdr_pkg::CDR_OP_STORE_TAG, cdr_pkg::CDR_TGT_ICACHE);
    `CHECK(kept_low, 32'hffff_ffc3)
    `CHECK(store_high, 32'h0000_000f)
    `CHECK(kept_check, 10'h0)
  endtask : t_stores

  task automatic t_errors();
    err(cdr_pkg::CDR_ERR_SINGLE, cdr_pkg::CDR_SRC_SCACHE, 17'h1_2345, 12'h400, 1'h0, 1'h0);
    rd(`CDR_REG_FAULT_CAPTURE, 32'h0);
    err(cdr_pkg::CDR_ERR_DOUBLE, cdr_pkg::CDR_SRC_SCACHE, 17'h1_2345, 12'h400, 1'h1, 1'h0);
    err(cdr_pkg::CDR_ERR_DOUBLE, cdr_pkg::CDR_SRC_SCACHE, 17'h1_2345, 12'h400, 1'h0, 1'h1);
    rd(`CDR_REG_FAULT_CAPTURE, {cdr_pkg::CDR_SRC_SCACHE, 4'h1, 9'h0, 17'h1_2345});
    err(cdr_pkg::CDR_ERR_PARITY, cdr_pkg::CDR_SRC_ICACHE, 17'h0_0abc, 12'hfff, 1'h0, 1'h1);
    rd(`CDR_REG_FAULT_CAPTURE, {cdr_pkg::CDR_SRC_SCACHE, 4'h9, 9'h0, 17'h1_2345});
    @(posedge core_clk);
    fault_release <= 1'h1;
    err(cdr_pkg::CDR_ERR_DOUBLE, cdr_pkg::CDR_SRC_SYSBUS, 17'h1_ffff, 12'hbff, 1'h0, 1'h1);
    rd(`CDR_REG_FAULT_CAPTURE, {cdr_pkg::CDR_SRC_SYSBUS, 4'h6, 6'h0, 3'h7, 17'h1_ffff});
    @(posedge core_clk);
    fault_release <= 1'h1;
    err(cdr_pkg::CDR_ERR_PARITY, cdr_pkg::CDR_SRC_DCACHE, 17'h1_ffff, 12'hbff, 1'h0, 1'h1);
    rd(`CDR_REG_FAULT_CAPTURE, {cdr_pkg::CDR_SRC_DCACHE, 4'h6, 6'h3f, 3'h0, 9'h0, 8'hff});
  endtask : t_errors

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'h1;
    t_moves();
    t_loads();
    t_stores();
    t_errors();
    summarize();
  end
endmodule : cache_diag_error_regs_test

/* File: bench/cdr_array_model.sv */
// Purpose: Cache array stand-in that answers load operations and keeps the last stored low word and check bits.
// Assumes: Load data are wanted in the operation cycle.
// Notes: Loads return all ones, so every bit that should be masked shows up if it is not.
module cdr_array_model (
  // Clock.
  input wire logic core_clk,
  // Array read side.
  output logic [31:0] array_low,
  output logic [31:0] array_high,
  output logic [9:0] array_check,
  // Array write side.
  input wire logic store_valid,
  input wire logic [31:0] store_low,
  input wire logic [9:0] store_check,
  output logic [31:0] kept_low,
  output logic [9:0] kept_check
);
  timeunit 1ns;
  timeprecision 1ns;
  assign array_low = 32'hffff_ffff;
  assign array_high = 32'hffff_ffff;
  assign array_check = 10'h3ff;
  always_ff @(posedge core_clk) begin
    if (store_valid) begin
      kept_low <= store_low;
      kept_check <= store_check;
    end
  end
endmodule : cdr_array_model

/* File: rtl/cdr_capture.sv */
// Purpose: Fault capture register with overrun tracking and cache error trap generation.
// Assumes: Error reports arrive as one-cycle pulses synchronous to core_clk.
// Notes: The held error is released by fault_release once the handler is done.
`include "cdr_params.svh"

module cdr_capture #(
  parameter bit LARGE_BLOCK = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Error report.
  input wire logic err_valid,
  input wire cdr_pkg::cdr_err_t err_kind,
  input wire cdr_pkg::cdr_source_t err_source,
  input wire logic [1:0] err_data_way,
  input wire logic [1:0] err_tag_way,
  input wire logic [1:0] err_state_way,
  input wire logic [1:0] err_mod_way,
  input wire logic inconsistent_block_error,
  input wire logic sysbus_address_fault,
  input wire logic sysbus_command_fault,
  input wire logic sysbus_response_fault,
  input wire logic [22:6] err_addr,
  // Control.
  input wire logic error_trap_disable,
  input wire logic fault_release,
  // Results.
  output logic [31:0] fault_capture,
  output logic cache_error_trap,
  output logic ecc_corrected
);
  cdr_pkg::cdr_cap_state_t state;
  wire is_ic = (err_source == cdr_pkg::CDR_SRC_ICACHE);
  wire is_dc = (err_source == cdr_pkg::CDR_SRC_DCACHE);
  wire is_sc = (err_source == cdr_pkg::CDR_SRC_SCACHE);
  wire is_sb = (err_source == cdr_pkg::CDR_SRC_SYSBUS);
  wire is_prim = is_ic | is_dc;
  wire uncorrectable = err_valid && (err_kind != cdr_pkg::CDR_ERR_SINGLE);
  wire take_trap = uncorrectable && !error_trap_disable;
  wire [16:0] sec_index = LARGE_BLOCK ? {err_addr[22:7], 1'b0} : err_addr[22:6];
  wire [16:0] prim_index = {9'h000, err_addr[13:6]};
  wire [31:0] fresh;

  // Fields outside the reporting source's format stay zero.
  assign fresh = ({30'h0, err_source} << `CDR_CAP_SRC)
    | ({31'h0, (is_dc | is_sb) & inconsistent_block_error} << `CDR_CAP_INCON)
    | ({30'h0, err_data_way} << `CDR_CAP_DWAY)
    | ({30'h0, is_sb ? 2'b00 : err_tag_way} << `CDR_CAP_TAWAY)
    | ({30'h0, is_prim ? err_state_way : 2'b00} << `CDR_CAP_TSWAY)
    | ({30'h0, is_dc ? err_mod_way : 2'b00} << `CDR_CAP_TMWAY)
    | ({31'h0, is_sb & sysbus_address_fault} << `CDR_CAP_SA)
    | ({31'h0, is_sb & sysbus_command_fault} << `CDR_CAP_SC)
    | ({31'h0, is_sb & sysbus_response_fault} << `CDR_CAP_SR)
    | {15'h0000, is_prim ? prim_index : sec_index};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cdr_pkg::CDR_CAP_EMPTY;
      fault_capture <= `CDR_WORD_RESET;
    end else if (take_trap && state == cdr_pkg::CDR_CAP_HELD) begin
      fault_capture[`CDR_CAP_OVR] <= 1'b1;
    end else if (take_trap) begin
      state <= cdr_pkg::CDR_CAP_HELD;
      fault_capture <= fresh;
    end else if (fault_release) begin
      state <= cdr_pkg::CDR_CAP_EMPTY;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_error_trap <= 1'b0;
      ecc_corrected <= 1'b0;
    end else begin
      cache_error_trap <= take_trap;
      ecc_corrected <= err_valid && (err_kind == cdr_pkg::CDR_ERR_SINGLE);
    end
  end

  property p_trap_on_uncorr;
    @(posedge core_clk) disable iff (!rst_n)
    take_trap |=> cache_error_trap;
  endproperty
  a_trap_on_uncorr: assert property (p_trap_on_uncorr)
    else $error("uncorrectable error raised no trap");

  property p_single_no_trap;
    @(posedge core_clk) disable iff (!rst_n)
    err_valid && err_kind == cdr_pkg::CDR_ERR_SINGLE |=> !cache_error_trap && ecc_corrected;
  endproperty
  a_single_no_trap: assert property (p_single_no_trap)
    else $error("single-bit error raised a trap");

  property p_overrun;
    @(posedge core_clk) disable iff (!rst_n)
    state == cdr_pkg::CDR_CAP_HELD && take_trap |=> fault_capture[`CDR_CAP_OVR];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_keep_first;
    @(posedge core_clk) disable iff (!rst_n)
    state == cdr_pkg::CDR_CAP_HELD |=> fault_capture[28:0] == $past(fault_capture[28:0]);
  endproperty
  a_keep_first: assert property (p_keep_first)
    else $error("held capture fields changed");
endmodule : cdr_capture

/* File: rtl/cdr_params.svh */
// Purpose: Offsets, field positions, reset values and masks of the cache diagnostic and error registers.
// Assumes: Coprocessor register numbers are five bits wide.
// Notes: Definitions only.
`ifndef CDR_PARAMS_SVH
`define CDR_PARAMS_SVH

// Coprocessor register numbers.
`define CDR_REG_CHECK_BITS 5'h1a
`define CDR_REG_FAULT_CAPTURE 5'h1b
`define CDR_REG_STAGING_LOW 5'h1c
`define CDR_REG_STAGING_HIGH 5'h1d

// Reset values.
`define CDR_CHECK_RESET 10'h000
`define CDR_WORD_RESET 32'h0000_0000

// Check-bit staging field positions.
`define CDR_CHK_SEC_PARITY 9
`define CDR_CHK_ICACHE_MASK 10'h001
`define CDR_CHK_DCACHE_MASK 10'h00f
`define CDR_CHK_SCACHE_MASK 10'h3ff

// Staging masks per operation and cache.
`define CDR_ITAG_LOW_MASK 32'hffff_ffc3
`define CDR_ITAG_HIGH_MASK 32'h0000_000f
`define CDR_DTAG_LOW_MASK 32'hffff_ffc1
`define CDR_DTAG_HIGH_MASK 32'he000_000f
`define CDR_IDATA_HIGH_MASK 32'h0000_000f
`define CDR_FULL_MASK 32'hffff_ffff
`define CDR_NONE_MASK 32'h0000_0000

// Tag field positions in the low staging register; CDR_DTAG_MOD_LSB is in the high staging register.
`define CDR_TAG_ADDR_LSB 8
`define CDR_ITAG_VALID 7
`define CDR_ITAG_LRU 6
`define CDR_ITAG_STATE_PAR 1
`define CDR_TAG_PAR 0
`define CDR_DTAG_STATE_LSB 6
`define CDR_DTAG_MOD_LSB 29

// Fault capture field positions.
`define CDR_CAP_SRC 30
`define CDR_CAP_OVR 29
`define CDR_CAP_INCON 28
`define CDR_CAP_DWAY 26
`define CDR_CAP_TAWAY 24
`define CDR_CAP_TSWAY 22
`define CDR_CAP_TMWAY 20
`define CDR_CAP_SA 19
`define CDR_CAP_SC 18
`define CDR_CAP_SR 17
`define CDR_CAP_IDX 0

`endif

/* File: rtl/cdr_pkg.sv */
// Purpose: Types shared by the cache diagnostic and error register files.
// Assumes: Nothing beyond the parameter header.
// Notes: Enumerations carry no explicit codes.
package cdr_pkg;
  typedef enum logic [1:0] {CDR_OP_LOAD_TAG, CDR_OP_STORE_TAG, CDR_OP_LOAD_DATA, CDR_OP_STORE_DATA} cdr_op_t;
  typedef enum logic [1:0] {CDR_TGT_ICACHE, CDR_TGT_DCACHE, CDR_TGT_SCACHE} cdr_target_t;
  typedef enum logic [1:0] {CDR_SRC_ICACHE, CDR_SRC_DCACHE, CDR_SRC_SCACHE, CDR_SRC_SYSBUS} cdr_source_t;
  typedef enum logic [1:0] {CDR_ERR_PARITY, CDR_ERR_SINGLE, CDR_ERR_DOUBLE} cdr_err_t;
  typedef enum logic [2:0] {
    CDR_LS_INVALID, CDR_LS_SHARED, CDR_LS_CLEAN_EXCL, CDR_LS_DIRTY_EXCL,
    CDR_LS_REFILL_CLEAN, CDR_LS_UPGRADE_SHARED, CDR_LS_UPGRADE_CLEAN, CDR_LS_REFILL_DIRTY
  } cdr_line_state_t;
  typedef enum logic {CDR_CAP_EMPTY, CDR_CAP_HELD} cdr_cap_state_t;
endpackage : cdr_pkg

/* File: rtl/cdr_regs.sv */
// Purpose: Check-bit staging, fault capture and tag staging registers with their cache operation paths.
// Assumes: Array read data accompany a load operation in the same cycle; all inputs synchronous.
// Notes: A cache operation wins over a coprocessor move that writes the same register in the same cycle.
`include "cdr_params.svh"

module cdr_regs #(
  parameter bit LARGE_BLOCK = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Coprocessor moves.
  input wire logic move_to_control,
  input wire logic move_from_control,
  input wire logic [4:0] cp0_addr,
  input wire logic [31:0] cp0_wdata,
  output logic [31:0] cp0_rdata,
  output logic cp0_rvalid,
  // Maintenance operation and array read data.
  input wire logic maintenance_op,
  input wire cdr_pkg::cdr_op_t op_kind,
  input wire cdr_pkg::cdr_target_t op_target,
  input wire logic [31:0] array_low,
  input wire logic [31:0] array_high,
  input wire logic [9:0] array_check,
  // Array write data.
  output logic store_valid,
  output logic [31:0] store_low,
  output logic [31:0] store_high,
  output logic [9:0] store_check,
  // Error reports.
  input wire logic err_valid,
  input wire cdr_pkg::cdr_err_t err_kind,
  input wire cdr_pkg::cdr_source_t err_source,
  input wire logic [1:0] err_data_way,
  input wire logic [1:0] err_tag_way,
  input wire logic [1:0] err_state_way,
  input wire logic [1:0] err_mod_way,
  input wire logic inconsistent_block_error,
  input wire logic sysbus_address_fault,
  input wire logic sysbus_command_fault,
  input wire logic sysbus_response_fault,
  input wire logic [22:6] err_addr,
  input wire logic error_trap_disable,
  input wire logic fault_release,
  // Status.
  output logic cache_error_trap,
  output logic ecc_corrected,
  output cdr_pkg::cdr_line_state_t dcache_line_state,
  output logic tag_parity_bad
);
  logic [9:0] check_bits;
  logic [31:0] staging_low;
  logic [31:0] staging_high;
  logic [31:0] fault_capture;

  // Check-bit lanes used per cache; all other lanes are unused.
  function automatic logic [9:0] check_mask(input cdr_pkg::cdr_target_t tgt);
    case (tgt)
      cdr_pkg::CDR_TGT_ICACHE: check_mask = `CDR_CHK_ICACHE_MASK;
      cdr_pkg::CDR_TGT_DCACHE: check_mask = `CDR_CHK_DCACHE_MASK;
      cdr_pkg::CDR_TGT_SCACHE: check_mask = `CDR_CHK_SCACHE_MASK;
      default: check_mask = 10'h000;
    endcase
  endfunction : check_mask

  // Meaningful bits of a staging word per op class, cache and half.
  function automatic logic [31:0] stage_mask(input logic is_tag, input cdr_pkg::cdr_target_t tgt, input logic hi);
    case (tgt)
      cdr_pkg::CDR_TGT_ICACHE: begin
        if (is_tag) begin
          stage_mask = hi ? `CDR_ITAG_HIGH_MASK : `CDR_ITAG_LOW_MASK;
        end else begin
          stage_mask = hi ? `CDR_IDATA_HIGH_MASK : `CDR_FULL_MASK;
        end
      end
      cdr_pkg::CDR_TGT_DCACHE: begin
        if (is_tag) begin
          stage_mask = hi ? `CDR_DTAG_HIGH_MASK : `CDR_DTAG_LOW_MASK;
        end else begin
          stage_mask = hi ? `CDR_NONE_MASK : `CDR_FULL_MASK;
        end
      end
      cdr_pkg::CDR_TGT_SCACHE: stage_mask = `CDR_FULL_MASK;
      default: stage_mask = `CDR_NONE_MASK;
    endcase
  endfunction : stage_mask

  // Data-cache line state from the two state bits and the refill modifier bit.
  function automatic cdr_pkg::cdr_line_state_t line_state(input logic refill, input logic [1:0] st);
    case ({refill, st})
      3'h0: line_state = cdr_pkg::CDR_LS_INVALID;
      3'h1: line_state = cdr_pkg::CDR_LS_SHARED;
      3'h2: line_state = cdr_pkg::CDR_LS_CLEAN_EXCL;
      3'h3: line_state = cdr_pkg::CDR_LS_DIRTY_EXCL;
      3'h4: line_state = cdr_pkg::CDR_LS_REFILL_CLEAN;
      3'h5: line_state = cdr_pkg::CDR_LS_UPGRADE_SHARED;
      3'h6: line_state = cdr_pkg::CDR_LS_UPGRADE_CLEAN;
      default: line_state = cdr_pkg::CDR_LS_REFILL_DIRTY;
    endcase
  endfunction : line_state

  // Operation decode.
  wire op_tag = (op_kind == cdr_pkg::CDR_OP_LOAD_TAG) || (op_kind == cdr_pkg::CDR_OP_STORE_TAG);
  wire op_load = (op_kind == cdr_pkg::CDR_OP_LOAD_TAG) || (op_kind == cdr_pkg::CDR_OP_LOAD_DATA);
  wire do_load = maintenance_op && op_load;
  wire do_store = maintenance_op && !op_load;
  wire data_load = do_load && !op_tag;
  wire tag_load = do_load && op_tag;
  wire [9:0] chk_mask = check_mask(op_target);
  wire [31:0] low_mask = stage_mask(op_tag, op_target, 1'b0);
  wire [31:0] high_mask = stage_mask(op_tag, op_target, 1'b1);
  wire [31:0] next_low_load = array_low & low_mask;
  wire [31:0] next_high_load = array_high & high_mask;
  wire [9:0] next_check_load = array_check & chk_mask;

  // Move decode.
  wire wr_check = move_to_control && (cp0_addr == `CDR_REG_CHECK_BITS);
  wire wr_low = move_to_control && (cp0_addr == `CDR_REG_STAGING_LOW);
  wire wr_high = move_to_control && (cp0_addr == `CDR_REG_STAGING_HIGH);
  wire [31:0] next_rdata = (cp0_addr == `CDR_REG_CHECK_BITS) ? {22'h000000, check_bits} :
    (cp0_addr == `CDR_REG_FAULT_CAPTURE) ? fault_capture :
    (cp0_addr == `CDR_REG_STAGING_LOW) ? staging_low :
    (cp0_addr == `CDR_REG_STAGING_HIGH) ? staging_high : 32'h0000_0000;

  // Instruction tag parity over loaded fields, both parities even.
  wire itag_bad = (^{next_low_load[31:`CDR_TAG_ADDR_LSB], next_high_load[3:0], next_low_load[`CDR_TAG_PAR]})
    | (next_low_load[`CDR_ITAG_VALID] ^ next_low_load[`CDR_ITAG_STATE_PAR]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_bits <= `CDR_CHECK_RESET;
    end else if (data_load) begin
      check_bits <= next_check_load;
    end else if (wr_check) begin
      check_bits <= cp0_wdata[9:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      staging_low <= `CDR_WORD_RESET;
      staging_high <= `CDR_WORD_RESET;
    end else begin
      if (do_load) begin
        staging_low <= next_low_load;
        staging_high <= next_high_load;
      end else begin
        if (wr_low) begin
          staging_low <= cp0_wdata;
        end
        if (wr_high) begin
          staging_high <= cp0_wdata;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_valid <= 1'b0;
      store_low <= `CDR_WORD_RESET;
      store_high <= `CDR_WORD_RESET;
      store_check <= `CDR_CHECK_RESET;
    end else begin
      store_valid <= do_store;
      if (do_store) begin
        store_low <= staging_low & low_mask;
        store_high <= staging_high & high_mask;
        store_check <= op_tag ? 10'h000 : (check_bits & chk_mask);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp0_rdata <= `CDR_WORD_RESET;
      cp0_rvalid <= 1'b0;
    end else begin
      cp0_rvalid <= move_from_control;
      if (move_from_control) begin
        cp0_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcache_line_state <= cdr_pkg::CDR_LS_INVALID;
      tag_parity_bad <= 1'b0;
    end else if (tag_load && op_target == cdr_pkg::CDR_TGT_DCACHE) begin
      dcache_line_state <= line_state(next_high_load[`CDR_DTAG_MOD_LSB + 2],
        next_low_load[`CDR_DTAG_STATE_LSB +: 2]);
      tag_parity_bad <= ^{next_low_load[31:`CDR_TAG_ADDR_LSB], next_high_load[3:0], next_low_load[`CDR_TAG_PAR]};
    end else if (tag_load && op_target == cdr_pkg::CDR_TGT_ICACHE) begin
      tag_parity_bad <= itag_bad;
    end
  end

  cdr_capture #(
    .LARGE_BLOCK(LARGE_BLOCK)
  ) u_capture (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .err_valid(err_valid),
    .err_kind(err_kind),
    .err_source(err_source),
    .err_data_way(err_data_way),
    .err_tag_way(err_tag_way),
    .err_state_way(err_state_way),
    .err_mod_way(err_mod_way),
    .inconsistent_block_error(inconsistent_block_error),
    .sysbus_address_fault(sysbus_address_fault),
    .sysbus_command_fault(sysbus_command_fault),
    .sysbus_response_fault(sysbus_response_fault),
    .err_addr(err_addr),
    .error_trap_disable(error_trap_disable),
    .fault_release(fault_release),
    .fault_capture(fault_capture),
    .cache_error_trap(cache_error_trap),
    .ecc_corrected(ecc_corrected)
  );

  property p_tag_skips_check;
    @(posedge core_clk) disable iff (!rst_n)
    tag_load && !wr_check |=> check_bits == $past(check_bits);
  endproperty
  a_tag_skips_check: assert property (p_tag_skips_check)
    else $error("tag operation changed check bits");

  property p_icache_data_load;
    @(posedge core_clk) disable iff (!rst_n)
    data_load && op_target == cdr_pkg::CDR_TGT_ICACHE |=> check_bits[9:1] == 9'h000 && staging_high[31:4] == 28'h0;
  endproperty
  a_icache_data_load: assert property (p_icache_data_load)
    else $error("instruction data load left unused bits set");

  property p_dcache_data_load;
    @(posedge core_clk) disable iff (!rst_n)
    data_load && op_target == cdr_pkg::CDR_TGT_DCACHE |=> check_bits == ($past(array_check) & 10'h00f)
      && staging_high == 32'h0;
  endproperty
  a_dcache_data_load: assert property (p_dcache_data_load)
    else $error("data-cache load parity field wrong");

  property p_sec_data_load;
    @(posedge core_clk) disable iff (!rst_n)
    data_load && op_target == cdr_pkg::CDR_TGT_SCACHE |=> check_bits == $past(array_check);
  endproperty
  a_sec_data_load: assert property (p_sec_data_load)
    else $error("secondary ECC and parity not staged");

  property p_store_ignores;
    @(posedge core_clk) disable iff (!rst_n)
    do_store && !op_tag && op_target == cdr_pkg::CDR_TGT_DCACHE |=> store_valid && store_check[9:4] == 6'h00;
  endproperty
  a_store_ignores: assert property (p_store_ignores)
    else $error("unused check bits driven on store");

  property p_check_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
    move_from_control && cp0_addr == `CDR_REG_CHECK_BITS |=> cp0_rvalid && cp0_rdata[31:10] == 22'h0;
  endproperty
  a_check_read_zero: assert property (p_check_read_zero)
    else $error("reserved check-bit positions read nonzero");

  property p_low_readback;
    @(posedge core_clk) disable iff (!rst_n)
    wr_low && !do_load ##1 move_from_control && cp0_addr == `CDR_REG_STAGING_LOW && !do_load
      |=> cp0_rdata == $past(cp0_wdata, 2);
  endproperty
  a_low_readback: assert property (p_low_readback)
    else $error("staging_low did not read back written value");

  property p_tag_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n)
    tag_load && op_target == cdr_pkg::CDR_TGT_ICACHE |=> staging_low[5:2] == 4'h0 && staging_high[31:4] == 28'h0;
  endproperty
  a_tag_reserved_zero: assert property (p_tag_reserved_zero)
    else $error("reserved tag fields loaded nonzero");

  property p_capture_read;
    @(posedge core_clk) disable iff (!rst_n)
    move_from_control && cp0_addr == `CDR_REG_FAULT_CAPTURE |=> cp0_rdata == $past(fault_capture);
  endproperty
  a_capture_read: assert property (p_capture_read)
    else $error("fault capture read mismatch");

  property p_check_write;
    @(posedge core_clk) disable iff (!rst_n)
    wr_check && !data_load |=> check_bits == $past(cp0_wdata[9:0]);
  endproperty
  a_check_write: assert property (p_check_write)
    else $error("check-bit staging write lost");

  property p_high_readback;
    @(posedge core_clk) disable iff (!rst_n)
    wr_high && !do_load ##1 move_from_control && cp0_addr == `CDR_REG_STAGING_HIGH && !do_load
      |=> cp0_rdata == $past(cp0_wdata, 2);
  endproperty
  a_high_readback: assert property (p_high_readback)
    else $error("staging_high did not read back written value");

  property p_capture_ro;
    @(posedge core_clk) disable iff (!rst_n)
    move_to_control && cp0_addr == `CDR_REG_FAULT_CAPTURE && !err_valid |=> fault_capture == $past(fault_capture);
  endproperty
  a_capture_ro: assert property (p_capture_ro)
    else $error("move changed the fault capture register");

  property p_tag_store_check;
    @(posedge core_clk) disable iff (!rst_n)
    do_store && op_tag |=> store_valid && store_check == 10'h000;
  endproperty
  a_tag_store_check: assert property (p_tag_store_check)
    else $error("tag store drove check bits");

  c_data_store: cover property (@(posedge core_clk) disable iff (!rst_n) do_store && !op_tag);
  c_tag_load_dc: cover property (@(posedge core_clk) disable iff (!rst_n)
    tag_load && op_target == cdr_pkg::CDR_TGT_DCACHE);
  c_trap: cover property (@(posedge core_clk) disable iff (!rst_n) cache_error_trap);
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_n) fault_capture[`CDR_CAP_OVR]);
endmodule : cdr_regs
